// [rtl/or_stack_pkg.sv]
// Functional notes
// - NOP changes nothing, takes one cycle
// - OR writes op1 OR op2 into register
// - OR sets zero; negative is V xor MSB
// - Indexed operand: pair zero/one, 5-bit offset
// - Bracketed form writes low address byte back
// - OR status register with immediate, flags untouched
// - Status bits at 01,02,04,40,80 masks
// - OR status with 02h equals interrupt enable
// - Plain pop drops two bytes, index minus two
// - Pop loads entry at index minus one
// - Pop to general register updates zero, negative
// - Push stores at index, then increments it
// - Six-bit index points at the empty entry
// - Return loads counter high byte from index minus one, low byte from minus two
package or_stack_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SC0 = 8'h08;
    localparam logic [7:0] OFS_GREG = 8'h0c;
    localparam logic [7:0] OFS_INDEX = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;
    localparam logic [7:0] OFS_PC = 8'h18;
    localparam logic [1:0] DMEM_REGION = 2'h1;

    // ----------------------------------------
    // Instruction word, status and index register fields
    // ----------------------------------------
    localparam int F_OP_LSB = 0;
    localparam int F_DST_LSB = 4;
    localparam int F_SRC_LSB = 6;
    localparam int F_IMM_LSB = 8;
    localparam int F_OFS_LSB = 16;
    localparam int F_PAIR_BIT = 21;
    localparam int F_FORM_LSB = 22;
    localparam int F_SEL_LSB = 24;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SPTR_LSB = 8;
    localparam int IDX_LOW0_LSB = 8;
    localparam int IDX_LOW1_LSB = 16;

    // ----------------------------------------
    // Flags and status/control bits
    // ----------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_V = 2;
    localparam int FLAG_N = 3;
    localparam logic [7:0] SC0_PAGED_MASK = 8'h01;
    localparam logic [7:0] SC0_GIE_MASK = 8'h02;
    localparam logic [7:0] SC0_BANK_MASK = 8'h04;
    localparam logic [7:0] SC0_IRQ0_MASK = 8'h40;
    localparam logic [7:0] SC0_IRQ1_MASK = 8'h80;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [7:0] SC0_RESET = 8'h00;
    localparam logic [5:0] SPTR_RESET = 6'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam int NOP_EXEC_CYCLES = 1;

    // ----------------------------------------
    // Operation, form and special register codes
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_NOP, OP_OR_DIR, OP_OR_IMM, OP_OR_REG, OP_OR_IDX, OP_OR_SC0,
        OP_POP_DROP, OP_POP_GREG, OP_POP_SREG, OP_PUSH_GREG, OP_PUSH_SREG, OP_RET
    } exec_op_t;

    localparam logic [1:0] FORM_PLAIN = 2'h0;
    localparam logic [1:0] FORM_BR_SUB = 2'h1;
    localparam logic [1:0] FORM_NWB_ADD = 2'h2;
    localparam logic [1:0] FORM_NWB_SUB = 2'h3;
    localparam logic [2:0] SEL_IHB = 3'h0;
    localparam logic [2:0] SEL_ILZ = 3'h1;
    localparam logic [2:0] SEL_ILO = 3'h2;
    localparam logic [2:0] SEL_SC0 = 3'h3;

endpackage : or_stack_pkg

// [rtl/or_flag_unit.sv]
`timescale 1ns/1ps
module or_flag_unit (
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic v_in,
    output logic [7:0] result,
    output logic zero,
    output logic negative
);
    always_comb begin
        result = op_a | op_b;
        zero = (result == 8'h00);
        negative = v_in ^ result[7];
    end
endmodule : or_flag_unit

// [rtl/stack_file.sv]
`timescale 1ns/1ps
module stack_file #(
    parameter int AW = 6
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr_a,
    output logic [7:0] rd_data_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [7:0] rd_data_b
);
    logic [7:0] mem [2**AW];

    generate
        if (AW < 1 || AW > 8) begin : g_bad_aw
            $error("stack_file: AW out of range");
        end
        for (genvar i = 0; i < 2**AW; i++) begin : g_entry
            always_ff @(posedge sys_clk) begin
                if (wr_en && wr_addr == AW'(i)) begin
                    mem[i] <= wr_data;
                end
            end
        end
    endgenerate

    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];
endmodule : stack_file

// [rtl/or_stack_nop_exec.sv]
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module or_stack_nop_exec #(
    parameter int DM_AW = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic exec_busy,
    output logic global_irq_enable,
    output logic irq0_enable,
    output logic irq1_enable,
    output logic index_bank_select,
    output logic paged_direct_enable
);
    generate
        if (DM_AW < 1 || DM_AW > 4) begin : g_bad_dm
            $error("or_stack_nop_exec: DM_AW must be 1 to 4");
        end
    endgenerate

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic exec_reg, exec_next;
    logic [31:0] instr_reg, instr_next;
    logic [7:0] sc0_reg, sc0_next;
    logic [3:0] flag_reg, flag_next;
    logic [3:0][7:0] greg_reg, greg_next;
    logic [7:0] ihb_reg, ihb_next;
    logic [7:0] ilz_reg, ilz_next;
    logic [7:0] ilo_reg, ilo_next;
    logic [5:0] sptr_reg, sptr_next;
    logic [15:0] pc_reg, pc_next;
    logic [2**DM_AW-1:0][7:0] dmem_reg, dmem_next;
    logic wr_pend_reg, wr_pend_next;
    logic rd_pend_reg, rd_pend_next;
    logic [7:0] addr_reg, addr_next;
    logic [31:0] hrdata_reg, hrdata_next;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    or_stack_pkg::exec_op_t op;
    logic [1:0] dst_f, src_f, form_f;
    logic [7:0] imm_f;
    logic [4:0] ofs_f;
    logic pair_f;
    logic [2:0] sel_f;
    logic [15:0] dir_addr, idx_base, idx_addr;
    logic [7:0] or_b, or_res, sel_val, push_data, stk_a, stk_b;
    logic or_z, or_n, is_or, stk_we;
    logic [5:0] sptr_m1, sptr_m2;
    logic [31:0] rd_mux;
    logic bus_take, bus_wr, dm_hit;

    assign op = or_stack_pkg::exec_op_t'(instr_reg[or_stack_pkg::F_OP_LSB +: 4]);
    assign dst_f = instr_reg[or_stack_pkg::F_DST_LSB +: 2];
    assign src_f = instr_reg[or_stack_pkg::F_SRC_LSB +: 2];
    assign imm_f = instr_reg[or_stack_pkg::F_IMM_LSB +: 8];
    assign ofs_f = instr_reg[or_stack_pkg::F_OFS_LSB +: 5];
    assign pair_f = instr_reg[or_stack_pkg::F_PAIR_BIT];
    assign form_f = instr_reg[or_stack_pkg::F_FORM_LSB +: 2];
    assign sel_f = instr_reg[or_stack_pkg::F_SEL_LSB +: 3];
    assign is_or = op inside {or_stack_pkg::OP_OR_DIR, or_stack_pkg::OP_OR_IMM,
                              or_stack_pkg::OP_OR_REG, or_stack_pkg::OP_OR_IDX};

    // Stack index wraps in six bits
    assign sptr_m1 = sptr_reg - 6'h01;
    assign sptr_m2 = sptr_reg - 6'h02;

    always_comb begin
        dir_addr = {(sc0_reg & or_stack_pkg::SC0_PAGED_MASK) != 8'h00 ? ihb_reg : 8'h00, imm_f};
        idx_base = {ihb_reg, pair_f ? ilo_reg : ilz_reg};
        if (form_f == or_stack_pkg::FORM_BR_SUB || form_f == or_stack_pkg::FORM_NWB_SUB) begin
            idx_addr = idx_base - {11'h000, ofs_f};
        end else begin
            idx_addr = idx_base + {11'h000, ofs_f};
        end
        unique case (op)
            or_stack_pkg::OP_OR_DIR: or_b = dmem_reg[dir_addr[DM_AW-1:0]];
            or_stack_pkg::OP_OR_REG: or_b = greg_reg[src_f];
            or_stack_pkg::OP_OR_IDX: or_b = dmem_reg[idx_addr[DM_AW-1:0]];
            default: or_b = imm_f;
        endcase
        unique case (sel_f)
            or_stack_pkg::SEL_IHB: sel_val = ihb_reg;
            or_stack_pkg::SEL_ILZ: sel_val = ilz_reg;
            or_stack_pkg::SEL_ILO: sel_val = ilo_reg;
            or_stack_pkg::SEL_SC0: sel_val = sc0_reg;
            default: sel_val = 8'h00;
        endcase
        push_data = (op == or_stack_pkg::OP_PUSH_GREG) ? greg_reg[src_f] : sel_val;
    end

    or_flag_unit u_or (
        .op_a(greg_reg[dst_f]),
        .op_b(or_b),
        .v_in(flag_reg[or_stack_pkg::FLAG_V]),
        .result(or_res),
        .zero(or_z),
        .negative(or_n)
    );

    assign stk_we = exec_reg && (op == or_stack_pkg::OP_PUSH_GREG || op == or_stack_pkg::OP_PUSH_SREG);

    stack_file #(.AW(6)) u_stack (
        .sys_clk(sys_clk),
        .wr_en(stk_we),
        .wr_addr(sptr_reg),
        .wr_data(push_data),
        .rd_addr_a(sptr_m1),
        .rd_data_a(stk_a),
        .rd_addr_b(sptr_m2),
        .rd_data_b(stk_b)
    );

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    assign bus_take = hsel && htrans[1] && hready;
    assign bus_wr = wr_pend_reg && !exec_reg;
    assign hreadyout = !exec_reg && !rd_pend_reg;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;
    // Data memory window, upper index bits must be clear for small sizes
    assign dm_hit = addr_reg[7:6] == or_stack_pkg::DMEM_REGION && (addr_reg[5:0] >> (DM_AW + 2)) == 6'h00;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_reg)
            or_stack_pkg::OFS_INSTR: rd_mux = instr_reg;
            or_stack_pkg::OFS_STATUS: begin
                rd_mux[or_stack_pkg::STAT_BUSY_BIT] = exec_reg;
                rd_mux[or_stack_pkg::STAT_SPTR_LSB +: 6] = sptr_reg;
            end
            or_stack_pkg::OFS_SC0: rd_mux[7:0] = sc0_reg;
            or_stack_pkg::OFS_GREG: rd_mux = greg_reg;
            or_stack_pkg::OFS_INDEX: rd_mux[23:0] = {ilo_reg, ilz_reg, ihb_reg};
            or_stack_pkg::OFS_FLAGS: rd_mux[3:0] = flag_reg;
            or_stack_pkg::OFS_PC: rd_mux[15:0] = pc_reg;
            default: begin
                if (dm_hit) begin
                    rd_mux[7:0] = dmem_reg[addr_reg[DM_AW+1:2]];
                end
            end
        endcase
    end

    always_comb begin
        addr_next = addr_reg;
        wr_pend_next = wr_pend_reg && exec_reg;
        rd_pend_next = rd_pend_reg && exec_reg;
        hrdata_next = hrdata_reg;
        if (rd_pend_reg && !exec_reg) begin
            hrdata_next = rd_mux;
        end
        if (bus_take) begin
            addr_next = haddr[7:0];
            wr_pend_next = hwrite;
            rd_pend_next = !hwrite;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr_reg <= 8'h00;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            addr_reg <= addr_next;
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            hrdata_reg <= hrdata_next;
        end
    end

    // ----------------------------------------
    // Execution core
    // ----------------------------------------
    always_comb begin
        exec_next = 1'b0;
        instr_next = instr_reg;
        sc0_next = sc0_reg;
        flag_next = flag_reg;
        greg_next = greg_reg;
        ihb_next = ihb_reg;
        ilz_next = ilz_reg;
        ilo_next = ilo_reg;
        sptr_next = sptr_reg;
        pc_next = pc_reg;
        dmem_next = dmem_reg;
        if (bus_wr) begin
            unique case (addr_reg)
                or_stack_pkg::OFS_INSTR: begin
                    instr_next = hwdata;
                    exec_next = 1'b1;
                end
                or_stack_pkg::OFS_SC0: sc0_next = hwdata[7:0];
                or_stack_pkg::OFS_GREG: greg_next = hwdata;
                or_stack_pkg::OFS_INDEX: begin
                    ihb_next = hwdata[7:0];
                    ilz_next = hwdata[or_stack_pkg::IDX_LOW0_LSB +: 8];
                    ilo_next = hwdata[or_stack_pkg::IDX_LOW1_LSB +: 8];
                end
                or_stack_pkg::OFS_FLAGS: flag_next = hwdata[3:0];
                or_stack_pkg::OFS_PC: pc_next = hwdata[15:0];
                default: begin
                    if (dm_hit) begin
                        dmem_next[addr_reg[DM_AW+1:2]] = hwdata[7:0];
                    end
                end
            endcase
        end
        if (exec_reg) begin
            unique case (op)
                or_stack_pkg::OP_NOP: ;
                or_stack_pkg::OP_OR_DIR, or_stack_pkg::OP_OR_IMM, or_stack_pkg::OP_OR_REG,
                or_stack_pkg::OP_OR_IDX: begin
                    greg_next[dst_f] = or_res;
                    flag_next[or_stack_pkg::FLAG_Z] = or_z;
                    flag_next[or_stack_pkg::FLAG_N] = or_n;
                    if (op == or_stack_pkg::OP_OR_IDX && form_f == or_stack_pkg::FORM_BR_SUB) begin
                        if (pair_f) begin
                            ilo_next = idx_addr[7:0];
                        end else begin
                            ilz_next = idx_addr[7:0];
                        end
                    end
                end
                or_stack_pkg::OP_OR_SC0: sc0_next = sc0_reg | imm_f;
                or_stack_pkg::OP_POP_DROP: sptr_next = sptr_m2;
                or_stack_pkg::OP_POP_GREG: begin
                    greg_next[dst_f] = stk_a;
                    flag_next[or_stack_pkg::FLAG_Z] = (stk_a == 8'h00);
                    flag_next[or_stack_pkg::FLAG_N] = stk_a[7];
                    sptr_next = sptr_m1;
                end
                or_stack_pkg::OP_POP_SREG: begin
                    unique case (sel_f)
                        or_stack_pkg::SEL_IHB: ihb_next = stk_a;
                        or_stack_pkg::SEL_ILZ: ilz_next = stk_a;
                        or_stack_pkg::SEL_ILO: ilo_next = stk_a;
                        or_stack_pkg::SEL_SC0: sc0_next = stk_a;
                        default: ;
                    endcase
                    sptr_next = sptr_m1;
                end
                or_stack_pkg::OP_PUSH_GREG, or_stack_pkg::OP_PUSH_SREG: sptr_next = sptr_reg + 6'h01;
                or_stack_pkg::OP_RET: begin
                    pc_next = {stk_a, stk_b};
                    sptr_next = sptr_m2;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            exec_reg <= 1'b0;
            instr_reg <= 32'h0000_0000;
            sc0_reg <= or_stack_pkg::SC0_RESET;
            flag_reg <= or_stack_pkg::FLAGS_RESET;
            greg_reg <= '0;
            ihb_reg <= 8'h00;
            ilz_reg <= 8'h00;
            ilo_reg <= 8'h00;
            sptr_reg <= or_stack_pkg::SPTR_RESET;
            pc_reg <= or_stack_pkg::PC_RESET;
            dmem_reg <= '0;
        end else begin
            exec_reg <= exec_next;
            instr_reg <= instr_next;
            sc0_reg <= sc0_next;
            flag_reg <= flag_next;
            greg_reg <= greg_next;
            ihb_reg <= ihb_next;
            ilz_reg <= ilz_next;
            ilo_reg <= ilo_next;
            sptr_reg <= sptr_next;
            pc_reg <= pc_next;
            dmem_reg <= dmem_next;
        end
    end

    assign exec_busy = exec_reg;
    assign paged_direct_enable = (sc0_reg & or_stack_pkg::SC0_PAGED_MASK) != 8'h00;
    assign global_irq_enable = (sc0_reg & or_stack_pkg::SC0_GIE_MASK) != 8'h00;
    assign index_bank_select = (sc0_reg & or_stack_pkg::SC0_BANK_MASK) != 8'h00;
    assign irq0_enable = (sc0_reg & or_stack_pkg::SC0_IRQ0_MASK) != 8'h00;
    assign irq1_enable = (sc0_reg & or_stack_pkg::SC0_IRQ1_MASK) != 8'h00;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_exec_one_cycle: assert property (exec_reg |=> !exec_reg)
        else $error("execution lasted more than one cycle");
    chk_nop_no_change: assert property (exec_reg && op == or_stack_pkg::OP_NOP |=>
        $stable(sc0_reg) && $stable(flag_reg) && $stable(greg_reg) && $stable(sptr_reg) && $stable(ilz_reg))
        else $error("nop changed state");
    chk_or_result: assert property (exec_reg && is_or |=>
        greg_reg[$past(dst_f)] == ($past(greg_reg[dst_f]) | $past(or_b)))
        else $error("or result wrong");
    chk_or_flags: assert property (exec_reg && is_or |=>
        flag_reg[or_stack_pkg::FLAG_Z] == (greg_reg[$past(dst_f)] == 8'h00)
        && flag_reg[or_stack_pkg::FLAG_N] == (flag_reg[or_stack_pkg::FLAG_V] ^ greg_reg[$past(dst_f)][7]))
        else $error("or flags wrong");
    chk_or_keeps_cv: assert property (exec_reg && is_or |=>
        flag_reg[or_stack_pkg::FLAG_C] == $past(flag_reg[or_stack_pkg::FLAG_C])
        && flag_reg[or_stack_pkg::FLAG_V] == $past(flag_reg[or_stack_pkg::FLAG_V]))
        else $error("or changed carry or overflow");
    chk_idx_writeback: assert property (exec_reg && op == or_stack_pkg::OP_OR_IDX && form_f == or_stack_pkg::FORM_BR_SUB
        |=> (pair_f ? ilo_reg : ilz_reg) == $past(idx_addr[7:0]))
        else $error("index writeback wrong");
    chk_idx_keep: assert property (exec_reg && op == or_stack_pkg::OP_OR_IDX && form_f[1]
        |=> $stable(ilz_reg) && $stable(ilo_reg) && $stable(ihb_reg))
        else $error("index changed in no-writeback form");
    chk_sc0_or: assert property (exec_reg && op == or_stack_pkg::OP_OR_SC0 |=>
        sc0_reg == ($past(sc0_reg) | $past(imm_f)) && $stable(flag_reg))
        else $error("status or wrong");
    chk_gie_by_or: assert property (exec_reg && op == or_stack_pkg::OP_OR_SC0 && imm_f == 8'h02 |=>
        global_irq_enable && ((sc0_reg ^ $past(sc0_reg)) & ~or_stack_pkg::SC0_GIE_MASK) == 8'h00)
        else $error("enable via status or wrong");
    chk_pop_drop: assert property (exec_reg && op == or_stack_pkg::OP_POP_DROP |=>
        sptr_reg == 6'($past(sptr_reg) - 6'h02) && $stable(flag_reg) && $stable(greg_reg))
        else $error("pop drop wrong");
    chk_pop_greg: assert property (exec_reg && op == or_stack_pkg::OP_POP_GREG |=>
        greg_reg[$past(dst_f)] == $past(stk_a) && sptr_reg == 6'($past(sptr_reg) - 6'h01)
        && flag_reg[or_stack_pkg::FLAG_Z] == ($past(stk_a) == 8'h00))
        else $error("pop to register wrong");
    chk_pop_sreg_flags: assert property (exec_reg && op == or_stack_pkg::OP_POP_SREG |=> $stable(flag_reg))
        else $error("pop to special register changed flags");
    chk_push_store: assert property (exec_reg && op == or_stack_pkg::OP_PUSH_GREG |=>
        stk_a == $past(push_data) && sptr_reg == 6'($past(sptr_reg) + 6'h01) && $stable(flag_reg))
        else $error("push wrong");
    chk_ret_pc: assert property (exec_reg && op == or_stack_pkg::OP_RET |=>
        pc_reg[7:0] == $past(stk_b) && sptr_reg == 6'($past(sptr_reg) - 6'h02))
        else $error("return wrong");

    cov_nop: cover property (exec_reg && op == or_stack_pkg::OP_NOP);
    cov_idx_wb: cover property (exec_reg && op == or_stack_pkg::OP_OR_IDX && form_f == or_stack_pkg::FORM_BR_SUB);
    cov_push_pop: cover property (exec_reg && op == or_stack_pkg::OP_PUSH_GREG ##[1:20]
        exec_reg && op == or_stack_pkg::OP_POP_GREG);
    cov_ret: cover property (exec_reg && op == or_stack_pkg::OP_RET);
endmodule : or_stack_nop_exec

// [dv/test_or_stack_nop_exec.sv]
`timescale 1ns/1ps
module test_or_stack_nop_exec;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rd_pend = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hready, hreadyout, hresp, exec_busy, gie, irq0, irq1, bank, paged;
    logic [31:0] hrdata;
    logic [31:0] exp_q[$];
    int fails = 0;
    int num_checks = 0;
    int n_exec = 0;
    int n_ex = 0;
    assign hready = hreadyout;
    or_stack_nop_exec u_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .exec_busy(exec_busy), .global_irq_enable(gie),
        .irq0_enable(irq0), .irq1_enable(irq1), .index_bank_select(bank), .paged_direct_enable(paged));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Bus master and comparison
    // ----------------------------------------
    task automatic give_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge sys_clk);
            n++;
            if (n > 50) begin
                fails++;
                give_verdict();
            end
        end
    endtask : wait_rdy
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) begin
            exp_q.push_back(d);
            rd_pend <= 1'b1;
        end
        wait_rdy();
        rd_pend <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, e);
    endtask : rd
    function automatic logic [31:0] ins(input or_stack_pkg::exec_op_t op, input logic [7:0] imm,
        input logic [1:0] dst = 2'h0, input logic [1:0] src = 2'h0, input logic [1:0] form = 2'h0,
        input logic [4:0] ofs = 5'h00, input logic pair = 1'b0, input logic [2:0] sel = 3'h0);
        ins = {5'h00, sel, form, pair, ofs, imm, src, dst, op};
    endfunction : ins
    task automatic ex(input logic [31:0] w);
        wr(or_stack_pkg::OFS_INSTR, w);
        n_ex++;
    endtask : ex
    // Read data phases are matched against the oldest note
    always @(posedge sys_clk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            chk(hrdata, exp_q.pop_front());
            chk({31'h0, hresp}, 32'h0);
        end
        if (exec_busy === 1'b1) n_exec++;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [7:0] a, b, d;
        logic [31:0] g;
        a = 8'($urandom(65));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        hsel <= 1'b1;
        @(posedge sys_clk);
        rd(or_stack_pkg::OFS_SC0, 0);
        rd(or_stack_pkg::OFS_STATUS, 0);
        rd(8'h30, 0);
        for (int i = 0; i < 2; i++) begin
            a = i ? 8'h00 : 8'($urandom);
            b = i ? 8'h00 : 8'($urandom);
            wr(or_stack_pkg::OFS_GREG, {24'h0, a});
            wr(or_stack_pkg::OFS_FLAGS, 32'h5);
            ex(ins(or_stack_pkg::OP_OR_IMM, b));
            d = a | b;
            rd(or_stack_pkg::OFS_GREG, {24'h0, d});
            rd(or_stack_pkg::OFS_FLAGS, {28'h0, ~d[7], 1'b1, d == 8'h0, 1'b1});
        end
        ex(ins(or_stack_pkg::OP_NOP, 8'hff));
        rd(or_stack_pkg::OFS_GREG, 0);
        rd(or_stack_pkg::OFS_FLAGS, 32'hf);
        g = $urandom;
        d = 8'($urandom);
        wr(or_stack_pkg::OFS_GREG, g);
        wr(8'h54, {24'h0, d});
        ex(ins(or_stack_pkg::OP_OR_REG, 0, 1, 0));
        ex(ins(or_stack_pkg::OP_OR_DIR, 8'h25, 2, 2));
        rd(or_stack_pkg::OFS_GREG, {g[31:24], g[23:16] | d, g[15:8] | g[7:0], g[7:0]});
        wr(8'h74, 32'h11);
        wr(8'h7c, 32'h22);
        for (int f = 0; f < 4; f++) begin
            wr(or_stack_pkg::OFS_INDEX, 32'h1e03);
            wr(or_stack_pkg::OFS_GREG, 0);
            ex(ins(or_stack_pkg::OP_OR_IDX, 0, 0, 0, 2'(f), 5'h1));
            rd(or_stack_pkg::OFS_GREG, (f % 2) ? 32'h11 : 32'h22);
            rd(or_stack_pkg::OFS_INDEX, (f == 1) ? 32'h1d03 : 32'h1e03);
        end
        ex(ins(or_stack_pkg::OP_OR_SC0, 8'h02));
        rd(or_stack_pkg::OFS_SC0, 32'h02);
        chk({27'h0, gie, irq0, irq1, bank, paged}, 32'h10);
        ex(ins(or_stack_pkg::OP_OR_SC0, 8'hc5));
        rd(or_stack_pkg::OFS_SC0, 32'hc7);
        chk({27'h0, gie, irq0, irq1, bank, paged}, 32'h1f);
        rd(or_stack_pkg::OFS_FLAGS, 32'hd);
        g = $urandom;
        wr(or_stack_pkg::OFS_GREG, g);
        wr(or_stack_pkg::OFS_FLAGS, 0);
        ex(ins(or_stack_pkg::OP_PUSH_GREG, 0, 0, 0));
        ex(ins(or_stack_pkg::OP_PUSH_GREG, 0, 1, 1));
        rd(or_stack_pkg::OFS_STATUS, 32'h200);
        rd(or_stack_pkg::OFS_FLAGS, 0);
        ex(ins(or_stack_pkg::OP_POP_GREG, 0, 3, 3));
        rd(or_stack_pkg::OFS_GREG, {g[15:8], g[23:0]});
        rd(or_stack_pkg::OFS_FLAGS, {28'h0, g[15], 1'b0, g[15:8] == 8'h0, 1'b0});
        ex(ins(or_stack_pkg::OP_POP_SREG, 0));
        rd(or_stack_pkg::OFS_INDEX, {24'h1e, g[7:0]});
        rd(or_stack_pkg::OFS_FLAGS, {28'h0, g[15], 1'b0, g[15:8] == 8'h0, 1'b0});
        rd(or_stack_pkg::OFS_STATUS, 0);
        ex(ins(or_stack_pkg::OP_PUSH_GREG, 0, 0, 0));
        ex(ins(or_stack_pkg::OP_PUSH_GREG, 0, 1, 1));
        ex(ins(or_stack_pkg::OP_RET, 0));
        rd(or_stack_pkg::OFS_PC, {16'h0, g[15:0]});
        rd(or_stack_pkg::OFS_STATUS, 0);
        ex(ins(or_stack_pkg::OP_POP_DROP, 0));
        rd(or_stack_pkg::OFS_STATUS, 32'h3e00);
        rd(or_stack_pkg::OFS_GREG, {g[15:8], g[23:0]});
        // Pair one with write-back, then push and pop of special registers
        wr(or_stack_pkg::OFS_INDEX, 32'h1e_0003);
        wr(or_stack_pkg::OFS_GREG, 0);
        ex(ins(or_stack_pkg::OP_OR_IDX, 0, 0, 0, or_stack_pkg::FORM_BR_SUB, 5'h01, 1'b1));
        ex(ins(or_stack_pkg::OP_PUSH_SREG, 0, 0, 0, 0, 0, 1'b0, 3'h2));
        ex(ins(or_stack_pkg::OP_POP_SREG, 0, 0, 0, 0, 0, 1'b0, 3'h3));
        rd(or_stack_pkg::OFS_GREG, 32'h11);
        rd(or_stack_pkg::OFS_INDEX, 32'h1d_0003);
        rd(or_stack_pkg::OFS_SC0, 32'h1d);
        rd(or_stack_pkg::OFS_STATUS, 32'h3e00);
        chk({27'h0, gie, irq0, irq1, bank, paged}, 32'h03);
        chk(n_exec, n_ex);
        give_verdict();
    end
endmodule : test_or_stack_nop_exec
